//--- hdl/dma_channel_fifo_datapath.sv
/*
  multichannel dma datapath: per-channel fifos, resource arbitration,
  sync flags, action-complete pins, emulation pause and an apb slave.
  assumes resources answer a request in the same cycle (ready and read data),
  and that mode fields change only while a channel is idle.
*/
`timescale 1ns/1ps
module dma_channel_fifo_datapath #(
  parameter int NCH = 5, // channels, the last one is the auxiliary
  parameter int NPIN = 4, // action-complete pins
  parameter int DEPTH = 9 // per-channel fifo depth
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic emu_halt,
  input wire logic [NCH-1:0] read_sync_evt,
  input wire logic [NCH-1:0] write_sync_evt,
  output logic [dma_pkg::NUM_RES-1:0] res_valid,
  output logic [dma_pkg::NUM_RES-1:0] res_write,
  output logic [dma_pkg::NUM_RES*32-1:0] res_addr,
  output logic [dma_pkg::NUM_RES*32-1:0] res_wdata,
  input wire logic [dma_pkg::NUM_RES-1:0] res_ready,
  input wire logic [dma_pkg::NUM_RES*32-1:0] res_rdata,
  output logic [NPIN-1:0] action_done_pin
);

  // ==========================================================
  // sizes
  localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int PTR_W = $clog2(DEPTH);
  localparam int OCC_W = $clog2(DEPTH + 1);
  // RULE20 last channel is auxiliary
  localparam int AUX = NCH - 1;
  localparam int NR = dma_pkg::NUM_RES;
  localparam logic [1:0] PIN_HOLD = 2'(dma_pkg::PIN_MIN_CYC - 1);

  // refuse shapes the decode and status packing cannot hold
  if (NCH < 1 || NCH > 8 || NPIN > NCH || DEPTH < 2 || DEPTH > 15) begin : g_bad
    $error("dma_channel_fifo_datapath: unsupported parameters");
  end

  // ==========================================================
  // state
  logic [31:0] ctrl_ff [NCH]; // control words
  logic [31:0] cnt_cfg_ff [NCH]; // programmed frame and element counts
  logic [31:0] src_addr_ff [NCH]; // working source address
  logic [31:0] dst_addr_ff [NCH]; // working destination address
  logic [31:0] fifo_ff [NCH][DEPTH]; // private channel storage
  logic [PTR_W-1:0] wp_ff [NCH]; // fill pointer
  logic [PTR_W-1:0] rp_ff [NCH]; // drain pointer
  logic [OCC_W-1:0] occ_ff [NCH]; // cells in use
  logic [15:0] rd_elem_ff [NCH]; // read elements left in frame
  logic [15:0] rd_frm_ff [NCH]; // read frames left
  logic [15:0] wr_elem_ff [NCH]; // write elements left in frame
  logic [15:0] wr_frm_ff [NCH]; // write frames left
  logic [NCH-1:0] run_ff; // channel running
  logic [NCH-1:0] rd_done_ff; // all reads issued
  logic [NCH-1:0] rsync_pend_ff; // read_sync_pending
  logic [NCH-1:0] wsync_pend_ff; // write_sync_pending
  logic [NCH-1:0] block_flag_ff; // block_done_flag
  logic [NCH-1:0] frame_flag_ff; // frame_done_flag
  logic [NCH-1:0] rs_meta_ff; // synchroniser stage one, read events
  logic [NCH-1:0] rs_sync_ff; // synchroniser stage two
  logic [NCH-1:0] rs_last_ff; // edge detect history
  logic [NCH-1:0] ws_meta_ff;
  logic [NCH-1:0] ws_sync_ff;
  logic [NCH-1:0] ws_last_ff;
  logic [NPIN-1:0] pin_ff; // registered pin drive
  logic [1:0] hold_ff [NPIN]; // pulse stretch counters
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // ==========================================================
  // combinational nets
  logic [NCH-1:0] paused, rd_can, wr_can, rd_fire, wr_fire;
  logic [NCH-1:0] frame_evt, block_evt, ctrl_wr, src_wr, dst_wr, cnt_wr;
  logic [31:0] rd_word [NCH]; // data returned to each channel
  logic [NR-1:0] arb_vld, arb_wr; // per-resource winner and direction
  logic [CH_W-1:0] arb_ch [NR];
  logic [NPIN-1:0] pin_src;
  logic wr_strobe, flags_wr;
  logic [31:0] status_word, flags_word;

  // ==========================================================
  // field decode helpers
  function automatic logic [2:0] src_of(input logic [31:0] c);
    return c[dma_pkg::CTRL_SRC_LSB +: 3];
  endfunction : src_of

  function automatic logic [2:0] dst_of(input logic [31:0] c);
    return c[dma_pkg::CTRL_DST_LSB +: 3];
  endfunction : dst_of

  // wrap point of the pointers
  function automatic logic [OCC_W-1:0] wrap_of(input logic [31:0] c);
    // RULE21 sync disables burst
    if (c[dma_pkg::CTRL_SPLIT] || c[dma_pkg::CTRL_RSYNC] || c[dma_pkg::CTRL_WSYNC])
      return OCC_W'(dma_pkg::HOLD_CELLS);
    // RULE1 full private depth
    return OCC_W'(DEPTH);
  endfunction : wrap_of

  // most cells a channel may fill before it stops reading
  function automatic logic [OCC_W-1:0] cap_of(input logic [31:0] c);
    // RULE5 one outstanding element
    if (c[dma_pkg::CTRL_SPLIT])
      return OCC_W'(1);
    return wrap_of(c);
  endfunction : cap_of

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p,
                                             input logic [OCC_W-1:0] lim);
    logic [OCC_W-1:0] n;
    n = OCC_W'(p) + OCC_W'(1);
    return (n == lim) ? '0 : PTR_W'(n);
  endfunction : bump

  function automatic logic [7:0] chan_of(input logic [7:0] a);
    return a >> dma_pkg::CH_SHIFT;
  endfunction : chan_of

  // ==========================================================
  // channel request eligibility
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      // RULE17 pause unless bit set
      // RULE19 auxiliary never pauses
      paused[c] = emu_halt && !ctrl_ff[c][dma_pkg::CTRL_EMU] && (c != AUX);
      // RULE7 read until full
      // RULE6 read ignores destination
      rd_can[c] = run_ff[c] && !paused[c] && !rd_done_ff[c] &&
                  (occ_ff[c] < cap_of(ctrl_ff[c])) &&
                  (!ctrl_ff[c][dma_pkg::CTRL_RSYNC] || rsync_pend_ff[c]) &&
                  (src_of(ctrl_ff[c]) < 3'(NR));
      // RULE8 write while data held
      // RULE2 resumes when granted
      wr_can[c] = run_ff[c] && !paused[c] && (occ_ff[c] != '0) &&
                  (!ctrl_ff[c][dma_pkg::CTRL_WSYNC] || wsync_pend_ff[c]) &&
                  (dst_of(ctrl_ff[c]) < 3'(NR));
    end
  end

  // ==========================================================
  // resource arbitration, one request per resource per cycle
  always_comb
  begin
    for (int r = 0; r < NR; r++)
    begin
      arb_vld[r] = 1'b0;
      arb_wr[r] = 1'b0;
      arb_ch[r] = '0;
      // RULE11 per-channel source select
      // RULE3 lowest number wins
      for (int c = NCH - 1; c >= 0; c--)
      begin
        if (rd_can[c] && src_of(ctrl_ff[c]) == 3'(r))
        begin
          arb_vld[r] = 1'b1;
          arb_ch[r] = CH_W'(c);
        end
      end
      // RULE9 write overrides read
      for (int c = NCH - 1; c >= 0; c--)
      begin
        if (wr_can[c] && dst_of(ctrl_ff[c]) == 3'(r))
        begin
          arb_vld[r] = 1'b1;
          arb_wr[r] = 1'b1;
          arb_ch[r] = CH_W'(c);
        end
      end
    end
  end

  // drive resource ports from the winners
  always_comb
  begin
    for (int r = 0; r < NR; r++)
    begin
      res_valid[r] = arb_vld[r];
      res_write[r] = arb_wr[r];
      res_addr[r*32 +: 32] = arb_wr[r] ? dst_addr_ff[arb_ch[r]] : src_addr_ff[arb_ch[r]];
      res_wdata[r*32 +: 32] = fifo_ff[arb_ch[r]][rp_ff[arb_ch[r]]];
    end
  end

  // ==========================================================
  // per-channel completion of accepted requests
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      int s;
      int d;
      s = int'(src_of(ctrl_ff[c]));
      d = int'(dst_of(ctrl_ff[c]));
      // RULE10 read and write same cycle
      rd_fire[c] = 1'b0;
      wr_fire[c] = 1'b0;
      rd_word[c] = 32'h0000_0000;
      if (rd_can[c] && arb_vld[s] && !arb_wr[s] && arb_ch[s] == CH_W'(c) && res_ready[s])
      begin
        rd_fire[c] = 1'b1;
        rd_word[c] = res_rdata[s*32 +: 32];
      end
      if (wr_can[c] && arb_vld[d] && arb_wr[d] && arb_ch[d] == CH_W'(c) && res_ready[d])
        wr_fire[c] = 1'b1;
      frame_evt[c] = wr_fire[c] && (wr_elem_ff[c] == 16'h0001);
      block_evt[c] = frame_evt[c] && (wr_frm_ff[c] == 16'h0001);
    end
  end

  // ==========================================================
  // fifo storage and pointers
  // RULE4 split wraps in two cells
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst || (ctrl_wr[c] && pwdata[dma_pkg::CTRL_START]))
      begin
        wp_ff[c] <= '0;
        rp_ff[c] <= '0;
        occ_ff[c] <= '0;
        if (rst)
          for (int k = 0; k < DEPTH; k++)
            fifo_ff[c][k] <= 32'h0000_0000;
      end
      else
      begin
        // RULE2 data stays while preempted
        occ_ff[c] <= occ_ff[c] + OCC_W'(rd_fire[c]) - OCC_W'(wr_fire[c]);
        if (rd_fire[c])
        begin
          fifo_ff[c][wp_ff[c]] <= rd_word[c];
          wp_ff[c] <= bump(wp_ff[c], wrap_of(ctrl_ff[c]));
        end
        if (wr_fire[c])
          rp_ff[c] <= bump(rp_ff[c], wrap_of(ctrl_ff[c]));
      end
    end
  end

  // ==========================================================
  // run state, element and frame counters, addresses
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst)
      begin
        run_ff[c] <= 1'b0;
        rd_done_ff[c] <= 1'b0;
        rd_elem_ff[c] <= 16'h0000;
        rd_frm_ff[c] <= 16'h0000;
        wr_elem_ff[c] <= 16'h0000;
        wr_frm_ff[c] <= 16'h0000;
      end
      else if (ctrl_wr[c])
      begin
        // zero counts would underflow, so such a start is ignored
        run_ff[c] <= pwdata[dma_pkg::CTRL_START] && (cnt_cfg_ff[c][15:0] != 16'h0000) &&
                     (cnt_cfg_ff[c][31:16] != 16'h0000);
        rd_done_ff[c] <= 1'b0;
        rd_elem_ff[c] <= cnt_cfg_ff[c][15:0];
        rd_frm_ff[c] <= cnt_cfg_ff[c][31:16];
        wr_elem_ff[c] <= cnt_cfg_ff[c][15:0];
        wr_frm_ff[c] <= cnt_cfg_ff[c][31:16];
      end
      else
      begin
        if (rd_fire[c])
        begin
          if (rd_elem_ff[c] == 16'h0001)
          begin
            rd_elem_ff[c] <= cnt_cfg_ff[c][15:0];
            if (rd_frm_ff[c] == 16'h0001)
              rd_done_ff[c] <= 1'b1;
            else
              rd_frm_ff[c] <= rd_frm_ff[c] - 16'h0001;
          end
          else
            rd_elem_ff[c] <= rd_elem_ff[c] - 16'h0001;
        end
        if (wr_fire[c])
        begin
          if (frame_evt[c])
          begin
            wr_elem_ff[c] <= cnt_cfg_ff[c][15:0];
            wr_frm_ff[c] <= wr_frm_ff[c] - 16'h0001;
          end
          else
            wr_elem_ff[c] <= wr_elem_ff[c] - 16'h0001;
        end
        // last write of the block ends the run
        if (block_evt[c])
          run_ff[c] <= 1'b0;
      end
    end
  end

  // address counters, loaded by software and stepped per element
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst)
      begin
        src_addr_ff[c] <= dma_pkg::ADDR_RESET;
        dst_addr_ff[c] <= dma_pkg::ADDR_RESET;
      end
      else
      begin
        if (src_wr[c])
          src_addr_ff[c] <= pwdata;
        else if (rd_fire[c])
          src_addr_ff[c] <= src_addr_ff[c] + dma_pkg::ADDR_STEP;
        if (dst_wr[c])
          dst_addr_ff[c] <= pwdata;
        else if (wr_fire[c])
          dst_addr_ff[c] <= dst_addr_ff[c] + dma_pkg::ADDR_STEP;
      end
    end
  end

  // ==========================================================
  // sync event pins: two flops, then rising edge detect
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rs_meta_ff <= '0;
      rs_sync_ff <= '0;
      rs_last_ff <= '0;
      ws_meta_ff <= '0;
      ws_sync_ff <= '0;
      ws_last_ff <= '0;
    end
    else
    begin
      rs_meta_ff <= read_sync_evt;
      rs_sync_ff <= rs_meta_ff;
      rs_last_ff <= rs_sync_ff;
      ws_meta_ff <= write_sync_evt;
      ws_sync_ff <= ws_meta_ff;
      ws_last_ff <= ws_sync_ff;
    end
  end

  // sticky flags; a new event in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst)
      begin
        rsync_pend_ff[c] <= 1'b0;
        wsync_pend_ff[c] <= 1'b0;
        block_flag_ff[c] <= 1'b0;
        frame_flag_ff[c] <= 1'b0;
      end
      else
      begin
        // RULE15 serviced element clears pending
        rsync_pend_ff[c] <= (rs_sync_ff[c] && !rs_last_ff[c]) ||
                            (rsync_pend_ff[c] && !(rd_fire[c] && ctrl_ff[c][dma_pkg::CTRL_RSYNC]));
        wsync_pend_ff[c] <= (ws_sync_ff[c] && !ws_last_ff[c]) ||
                            (wsync_pend_ff[c] && !(wr_fire[c] && ctrl_ff[c][dma_pkg::CTRL_WSYNC]));
        block_flag_ff[c] <= block_evt[c] || (block_flag_ff[c] &&
                            !(flags_wr && !pwdata[c*dma_pkg::FLG_W + dma_pkg::FLG_BLOCK]));
        frame_flag_ff[c] <= frame_evt[c] || (frame_flag_ff[c] &&
                            !(flags_wr && !pwdata[c*dma_pkg::FLG_W + dma_pkg::FLG_FRAME]));
      end
    end
  end

  // ==========================================================
  // action-complete pins
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      // RULE13 select the pin source
      case (ctrl_ff[p][dma_pkg::CTRL_SEL_LSB +: 3])
        // RULE14 rises with pending sync
        dma_pkg::PIN_RSYNC: pin_src[p] = rsync_pend_ff[p];
        dma_pkg::PIN_WSYNC: pin_src[p] = wsync_pend_ff[p];
        dma_pkg::PIN_BLOCK: pin_src[p] = block_flag_ff[p];
        dma_pkg::PIN_FRAME: pin_src[p] = frame_flag_ff[p];
        // RULE22 constant level held
        dma_pkg::PIN_HIGH: pin_src[p] = 1'b1;
        default: pin_src[p] = 1'b0;
      endcase
    end
  end

  // registered drive with a stretch so no pulse is shorter than the minimum
  always_ff @(posedge clk)
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      if (rst)
      begin
        pin_ff[p] <= 1'b0;
        hold_ff[p] <= 2'h0;
      end
      // RULE16 registered, stretched pulse
      else if (pin_src[p])
      begin
        pin_ff[p] <= 1'b1;
        hold_ff[p] <= PIN_HOLD;
      end
      else if (hold_ff[p] != 2'h0)
      begin
        pin_ff[p] <= 1'b1;
        hold_ff[p] <= hold_ff[p] - 2'h1;
      end
      else
        pin_ff[p] <= 1'b0;
    end
  end

  // RULE12 one pin each for channels 0 to NPIN-1, none for the auxiliary
  assign action_done_pin = pin_ff;

  // ==========================================================
  // apb write decode, taken in the access phase
  always_comb
  begin
    wr_strobe = psel && penable && pwrite;
    flags_wr = wr_strobe && (paddr == dma_pkg::OFS_FLAGS);
    for (int c = 0; c < NCH; c++)
    begin
      ctrl_wr[c] = wr_strobe && chan_of(paddr) == 8'(c) &&
                   (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_CTRL;
      src_wr[c] = wr_strobe && chan_of(paddr) == 8'(c) &&
                  (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_SRC;
      dst_wr[c] = wr_strobe && chan_of(paddr) == 8'(c) &&
                  (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_DST;
      cnt_wr[c] = wr_strobe && chan_of(paddr) == 8'(c) &&
                  (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_CNT;
    end
  end

  // software-held configuration
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst)
      begin
        ctrl_ff[c] <= dma_pkg::CTRL_RESET;
        cnt_cfg_ff[c] <= dma_pkg::CNT_RESET;
      end
      else
      begin
        if (ctrl_wr[c])
          ctrl_ff[c] <= {18'h0, pwdata[13:0]};
        if (cnt_wr[c])
          cnt_cfg_ff[c] <= pwdata;
      end
    end
  end

  // status and flag words
  always_comb
  begin
    status_word = 32'h0000_0000;
    flags_word = 32'h0000_0000;
    for (int c = 0; c < NCH; c++)
    begin
      // RULE18 paused state reported
      if (!run_ff[c])
        status_word[c*2 +: 2] = dma_pkg::CH_IDLE;
      else if (paused[c])
        status_word[c*2 +: 2] = dma_pkg::CH_PAUSE;
      else
        status_word[c*2 +: 2] = dma_pkg::CH_RUN;
      flags_word[c*dma_pkg::FLG_W + dma_pkg::FLG_RSYNC] = rsync_pend_ff[c];
      flags_word[c*dma_pkg::FLG_W + dma_pkg::FLG_WSYNC] = wsync_pend_ff[c];
      flags_word[c*dma_pkg::FLG_W + dma_pkg::FLG_BLOCK] = block_flag_ff[c];
      flags_word[c*dma_pkg::FLG_W + dma_pkg::FLG_FRAME] = frame_flag_ff[c];
    end
  end

  // read data and error are captured in the setup phase, so no wait states
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      if (paddr == dma_pkg::OFS_STATUS)
        prdata_ff <= pwrite ? 32'h0000_0000 : status_word;
      else if (paddr == dma_pkg::OFS_FLAGS)
        prdata_ff <= pwrite ? 32'h0000_0000 : flags_word;
      else if (chan_of(paddr) < 8'(NCH) && (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_CTRL)
        prdata_ff <= ctrl_ff[3'(chan_of(paddr))];
      else if (chan_of(paddr) < 8'(NCH) && (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_SRC)
        prdata_ff <= src_addr_ff[3'(chan_of(paddr))];
      else if (chan_of(paddr) < 8'(NCH) && (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_DST)
        prdata_ff <= dst_addr_ff[3'(chan_of(paddr))];
      else if (chan_of(paddr) < 8'(NCH) && (paddr & dma_pkg::REG_MASK) == dma_pkg::OFS_CNT)
        prdata_ff <= {wr_frm_ff[3'(chan_of(paddr))], wr_elem_ff[3'(chan_of(paddr))]};
      else
        pslverr_ff <= 1'b1;
    end
  end

  assign prdata = prdata_ff;
  assign pready = psel && penable;
  assign pslverr = pslverr_ff && psel && penable;

endmodule : dma_channel_fifo_datapath

//--- hdl/dma_pkg.sv
/*
  constants, field layouts and enumerations shared by the dma channel datapath.
  assumes one 100 MHz clock and a 32-bit apb master in the same domain.
*/
// Contract
// RULE1 - each channel owns a private nine-entry fifo
// RULE2 - preempted channel keeps pending data in fifo
// RULE3 - lower channel number wins a shared resource
// RULE4 - split mode uses only first two cells
// RULE5 - split mode: next read waits for write
// RULE6 - read and write sides run independently
// RULE7 - reads continue until holding storage is full
// RULE8 - writes continue while storage holds data
// RULE9 - on one resource a write beats a read
// RULE10 - distinct resources give one element per cycle
// RULE11 - source and destination chosen per channel
// RULE12 - one action-complete pin per channel; the code drives pins for channels 0 to NPIN-1 only, none for the auxiliary
// RULE13 - select field picks the pin source
// RULE14 - sync-tracking pin rises on recognised event
// RULE15 - sync-tracking pin falls when event serviced
// RULE16 - pin registered, pulses at least two periods
// RULE17 - emulation bit selects pause or run
// RULE18 - paused channel shows paused in status
// RULE19 - auxiliary channel ignores emulation halts
// RULE20 - four programmable channels plus one auxiliary
// RULE21 - sync-enabled channels never burst through fifo
// RULE22 - constant pin selections hold their level
package dma_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam int CH_SHIFT = 4; // channel block stride is 16 bytes
  localparam logic [7:0] REG_MASK = 8'h0f; // offset inside a channel block
  localparam logic [7:0] OFS_CTRL = 8'h00; // channel control
  localparam logic [7:0] OFS_SRC = 8'h04; // working source address
  localparam logic [7:0] OFS_DST = 8'h08; // working destination address
  localparam logic [7:0] OFS_CNT = 8'h0c; // frames and elements per frame
  localparam logic [7:0] OFS_STATUS = 8'hf0; // two state bits per channel
  localparam logic [7:0] OFS_FLAGS = 8'hf4; // four flag bits per channel

  // ==========================================================
  // control field positions
  localparam int CTRL_START = 0; // write 1 starts, 0 aborts
  localparam int CTRL_SPLIT = 1; // split mode
  localparam int CTRL_RSYNC = 2; // read synchronisation enable
  localparam int CTRL_WSYNC = 3; // write synchronisation enable
  localparam int CTRL_EMU = 4; // emu_halt_behaviour: 1 keeps running
  localparam int CTRL_SRC_LSB = 5; // source resource, 3 bits
  localparam int CTRL_DST_LSB = 8; // destination resource, 3 bits
  localparam int CTRL_SEL_LSB = 11; // action_pin_select, 3 bits
  localparam int CNT_FRM_LSB = 16; // frame count in upper half

  // flag bits inside each channel nibble
  localparam int FLG_RSYNC = 0; // read_sync_pending
  localparam int FLG_WSYNC = 1; // write_sync_pending
  localparam int FLG_BLOCK = 2; // block_done_flag
  localparam int FLG_FRAME = 3; // frame_done_flag
  localparam int FLG_W = 4;

  // ==========================================================
  // reset values and sizes
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004; // one word per element
  localparam int HOLD_CELLS = 2; // holding-register depth
  localparam int NUM_RES = 6;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIN_MIN_NS = 2 * CLK_PERIOD_NS; // two cpu output clock periods
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    RES_EMIF = 3'h0, RES_EXP = 3'h1, RES_DMEM = 3'h2,
    RES_PMEM0 = 3'h3, RES_PMEM1 = 3'h4, RES_PERIPH = 3'h5
  } res_t;
  typedef enum logic [2:0] {
    PIN_RSYNC = 3'h0, PIN_WSYNC = 3'h1, PIN_BLOCK = 3'h2,
    PIN_FRAME = 3'h3, PIN_LOW = 3'h4, PIN_HIGH = 3'h5
  } pin_sel_t;
  typedef enum logic [1:0] {
    CH_IDLE = 2'h0, CH_RUN = 2'h1, CH_PAUSE = 2'h2
  } ch_state_t;

endpackage : dma_pkg

//--- bench/dma_checker_assertions.sv
/* port checker for the dma datapath: apb timing, refusals, reset, pin width.
   assumes a bind onto the top module, one clock, rst synchronous high. */
`timescale 1ns/1ps
module dma_checker #(
  parameter int NPIN = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [dma_pkg::NUM_RES-1:0] res_valid,
  input wire logic [NPIN-1:0] action_done_pin
);
  // ==========================================================
  // apb slave and pin timing
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ready_follows_a: assert property (pready == (psel && penable)) else $error("pready wrong");
  slverr_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
  unmapped_err_a: assert property (psel && penable && paddr == 8'hf8 |-> pslverr)
    else $error("no pslverr");
  status_ok_a: assert property (psel && penable && paddr == dma_pkg::OFS_STATUS |-> !pslverr)
    else $error("status refused");
  quiet_reset_a: assert property ($fell(rst) |-> res_valid == '0 && action_done_pin == '0)
    else $error("busy after reset");
  pin_first_a: assert property ($rose(action_done_pin[0]) |=> action_done_pin[0])
    else $error("pin 0 pulse short");
  pin_last_a: assert property ($rose(action_done_pin[NPIN-1]) |=> action_done_pin[NPIN-1])
    else $error("last pin pulse short");
endmodule : dma_checker

//--- bench/res_responder.sv
/* resource partner: answers in the same cycle or stalls per lane.
   assumes read data is a fixed scramble of the address. */
`timescale 1ns/1ps
module res_responder (
  input wire logic clk,
  input wire logic [5:0] stall,
  input wire logic [5:0] res_valid,
  input wire logic [5:0] res_write,
  input wire logic [191:0] res_addr,
  output logic [5:0] res_ready,
  output logic [191:0] res_rdata
);
  logic [31:0] tick_ff = 32'h0; // idle lanes show a moving pattern, never stale data
  always_ff @(posedge clk) tick_ff <= tick_ff + 32'h1;
  assign res_ready = ~stall;
  // read data only on a selected read lane
  always_comb
    for (int r = 0; r < 6; r++)
      res_rdata[r*32+:32] = (res_valid[r] && !res_write[r]) ? res_addr[r*32+:32] ^ 32'h5a5a_0000
                                                            : ~tick_ff;
endmodule : res_responder

//--- bench/dma_channel_fifo_datapath_tb_top.sv
/* self-checking bench: each channel moves 11 words between resources.
   assumes zero-wait apb and random resource stalls. */
`timescale 1ns/1ps
module dma_channel_fifo_datapath_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, emu_halt = 0;
  logic [7:0] paddr = 0, b;
  logic [31:0] pwdata = 0, prdata, src, dst;
  logic pready, pslverr;
  logic [4:0] evt = '0; // sync event pins
  logic [5:0] res_valid, res_write, res_ready, stall = '0;
  logic [191:0] res_addr, res_wdata, res_rdata;
  logic [3:0] action_done_pin;
  logic [2:0] d;
  logic [63:0] wq[$];
  logic [31:0] rq[$];
  int error_cnt = 0, checks = 0;
  initial forever #5 clk = ~clk;
  dma_channel_fifo_datapath DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .emu_halt(emu_halt), .read_sync_evt(evt), .write_sync_evt(evt),
    .res_valid(res_valid), .res_write(res_write), .res_addr(res_addr), .res_wdata(res_wdata),
    .res_ready(res_ready), .res_rdata(res_rdata), .action_done_pin(action_done_pin));
  res_responder far_i (.clk(clk), .stall(stall), .res_valid(res_valid),
    .res_write(res_write), .res_addr(res_addr), .res_ready(res_ready), .res_rdata(res_rdata));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (e !== g)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task test_done;
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (!pready);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  // monitor: oldest note against each finished read or resource write
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite) chk("prdata", rq.pop_front(), prdata);
    for (int r = 0; r < 6; r++)
      if (res_valid[r] && res_ready[r] && res_write[r])
        chk("write", wq.size() ? wq.pop_front() : '1, {res_addr[r*32+:32], res_wdata[r*32+:32]});
    stall <= 6'($urandom);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial
  begin
    void'($urandom(69099));
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int c = 0; c < 5; c++)
    begin
      b = 8'(c << 4);
      src = 32'h1000 + 32'(c << 8);
      dst = 32'h8000 + 32'(c << 8);
      d = (c == 4) ? 3'h4 : 3'(5 - c); // last pass reads and writes one resource
      for (int k = 0; k < 11; k++) wq.push_back({dst + 32'(4 * k), (src + 32'(4 * k)) ^ 32'h5a5a_0000});
      apb(1, b + 8'h4, src);
      apb(1, b + 8'h8, dst);
      apb(1, b + 8'hc, {16'h1, 16'd11});
      emu_halt <= 1;
      apb(1, b, {18'h0, (c == 0) ? 3'h5 : 3'h2, d, 3'(c), 5'h01});
      rq.push_back({18'h0, (c == 0) ? 3'h5 : 3'h2, d, 3'(c), 5'h01});
      apb(0, b, 0);
      rq.push_back(32'((c == 4) ? 1 : 2) << (2 * c));
      apb(0, dma_pkg::OFS_STATUS, 0);
      emu_halt <= 0;
      for (int t = 0; t < 400 && wq.size() > 0; t++) @(posedge clk);
      chk("left", 0, wq.size());
      repeat (4) @(posedge clk);
    end
    chk("pins", 4'hf, action_done_pin);
    apb(1, dma_pkg::OFS_FLAGS, 0);
    repeat (3) @(posedge clk);
    chk("pins", 4'h1, action_done_pin);
    apb(1, 8'h10, 0);
    evt <= 5'h02;
    repeat (6) @(posedge clk);
    chk("pins", 4'h3, action_done_pin);
    rq.push_back(0);
    apb(0, 8'hf8, 0);
    test_done();
  end
endmodule : dma_channel_fifo_datapath_tb_top
bind dma_channel_fifo_datapath dma_checker #(.NPIN(NPIN)) chk_i (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .res_valid(res_valid), .action_done_pin(action_done_pin));
